// *** hdl/boot_config_set_handler.sv ***
`timescale 1ns/1ps
`default_nettype none
module boot_config_set_handler #(
  parameter int MAX_TLVS = boot_cfg_pkg::TLV_LIMIT
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        cmdValid,
  input  wire logic [7:0]  cmdData,
  input  wire logic        cmdLast,
  input  wire logic        cmdDrop,
  output logic             cmdReady,
  output logic             rspValid,
  input  wire logic        rspReady,
  output logic [7:0]       rspType,
  output logic [7:0]       rspPartition,
  output logic [15:0]      rspCode,
  output logic [15:0]      rspReason,
  output logic [31:0]      rspBitmap,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             irq
);
  import boot_cfg_pkg::*;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic attr_kind_t attr_kind(input logic [7:0] code);
    logic [7:0] slot;
    slot = code % CODE_STRIDE;
    if (code >= CODE_RSVD_FIRST)
      return KIND_RSVD;
    else if (slot < SLOT_BOOL)
      return KIND_STR;
    else if (slot == SLOT_BOOL)
      return KIND_BOOL;
    else if (slot <= SLOT_U32_LAST)
      return KIND_U32;
    else
      return KIND_RSVD;
  endfunction

  function automatic logic tlv_ok(input attr_kind_t kind, input logic [7:0] len);
    return (kind != KIND_RSVD) &&
           (len == 8'h00 || kind == KIND_STR || (kind == KIND_BOOL && len == LEN_BOOL) ||
            (kind == KIND_U32 && len == LEN_U32));
  endfunction

  function automatic logic [7:0] strb_byte(input logic [7:0] old, input logic [31:0] d,
                                           input logic [3:0] s, input int lane);
    return s[lane] ? d[lane*8 +: 8] : old;
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  parse_state_t  state;
  logic [4:0]    byteCnt;
  logic [7:0]    rxType;
  logic [7:0]    rxPartition;
  logic [7:0]    rxProto;
  logic [7:0]    tlvCount;
  logic [7:0]    tlvIdx;
  logic [7:0]    curLen;
  logic [7:0]    curCode;
  logic [7:0]    valCnt;
  logic [7:0]    valSeen;
  logic [31:0]   errMap;
  logic [5:0]    commitIdx;
  logic [7:0]    protoReg;
  logic [1:0]    irqStatus;
  logic [1:0]    irqMask;
  logic [5:0]    attrSel;
  logic [7:0]    awAddrReg;
  logic          awHave;
  logic [31:0]   wDataReg;
  logic [3:0]    wStrbReg;
  logic          wHave;

  logic [7:0]    stageCode [MAX_TLVS];
  logic [7:0]    stageLen  [MAX_TLVS];
  logic [31:0]   stageVal  [MAX_TLVS];
  logic [7:0]    storeLen  [STORE_SLOTS];
  logic [31:0]   storeVal  [STORE_SLOTS];

  logic          take;
  logic          tlvInRange;
  logic [4:0]    slotIdx;
  logic          countBad;
  logic          protoBad;
  logic          cmdFail;
  logic          commitDone;
  logic          commitWrite;
  logic          ownCmd;
  logic          truncated;
  logic [7:0]    nextIdx;
  logic          wrFire;
  logic          rdFire;

  assign cmdReady    = (state != S_COMMIT) && (state != S_RESP);
  assign take        = ce && cmdValid && cmdReady;
  assign slotIdx     = tlvIdx[4:0];
  assign tlvInRange  = tlvIdx < 8'(MAX_TLVS);
  assign nextIdx     = tlvIdx + 8'h01;
  assign countBad    = tlvCount > 8'(MAX_TLVS);
  assign protoBad    = rxProto != protoReg;  // R7
  assign cmdFail     = countBad || protoBad || (|errMap);  // R13
  assign commitDone  = (state == S_COMMIT) && (cmdFail || {2'b00, commitIdx} == tlvCount);
  assign commitWrite = ce && (state == S_COMMIT) && !commitDone;
  assign ownCmd      = (rxType == CMD_TYPE) && !cmdDrop && !(state == S_HDR && byteCnt < COUNT_POS); // R8 R11
  assign truncated   = (state == S_LEN) || (state == S_CODE) || (state == S_VAL && valCnt != 8'h01) ||
                       (state == S_HDR && cmdData != 8'h00);
  assign rspValid    = state == S_RESP;

  // ---------------------------------------------------------------
  // command parser and response builder
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state        <= S_HDR;
      byteCnt      <= 5'h00;
      rxType       <= 8'h00;
      rxPartition  <= 8'h00;
      rxProto      <= 8'h00;
      tlvCount     <= 8'h00;
      tlvIdx       <= 8'h00;
      curLen       <= 8'h00;
      curCode      <= 8'h00;
      valCnt       <= 8'h00;
      valSeen      <= 8'h00;
      errMap       <= 32'h0000_0000;
      commitIdx    <= 6'h00;
      rspType      <= 8'h00;
      rspPartition <= 8'h00;
      rspCode      <= 16'h0000;
      rspReason    <= 16'h0000;
      rspBitmap    <= 32'h0000_0000;
    end
    else if (ce)
    begin
      unique case (state)
        S_HDR:
          if (take)
          begin
            byteCnt <= byteCnt + 5'h01;
            if (byteCnt == HDR_TYPE_POS) rxType <= cmdData;
            if (byteCnt == PART_POS) rxPartition <= cmdData;
            if (byteCnt == PROTO_POS) rxProto <= cmdData;
            if (byteCnt == COUNT_POS)  // R10
            begin
              tlvCount <= cmdData;
              state    <= (cmdData == 8'h00) ? S_SKIP : S_LEN;
            end
          end
        S_LEN:
          if (take)
          begin
            curLen <= cmdData;  // R1
            state  <= S_CODE;
          end
        S_CODE:
          if (take)
          begin
            curCode <= cmdData;  // R1
            valCnt  <= curLen;
            valSeen <= 8'h00;
            if (tlvInRange && !tlv_ok(attr_kind(cmdData), curLen))
              errMap[slotIdx] <= 1'b1;  // R14 R17
            if (curLen != 8'h00)
              state <= S_VAL;
            else
            begin
              tlvIdx <= nextIdx;
              state  <= (nextIdx == tlvCount) ? S_SKIP : S_LEN;
            end
          end
        S_VAL:
          if (take)
          begin
            valCnt  <= valCnt - 8'h01;  // R18
            valSeen <= valSeen + 8'h01;
            if (tlvInRange && attr_kind(curCode) == KIND_STR && (cmdData < ASCII_LOW || cmdData > ASCII_HIGH))
              errMap[slotIdx] <= 1'b1;  // R3
            if (valCnt == 8'h01)
            begin
              tlvIdx <= nextIdx;
              state  <= (nextIdx == tlvCount) ? S_SKIP : S_LEN;
            end
          end
        S_SKIP:
          ;
        S_COMMIT:
        begin
          commitIdx <= commitIdx + 6'h01;  // R2
          if (commitDone)
          begin
            state        <= S_RESP;
            rspType      <= RSP_TYPE;  // R9
            rspPartition <= rxPartition;
            rspCode      <= cmdFail ? RSP_FAILED : RSP_COMPLETED;                 // R12 R15
            rspReason    <= cmdFail ? RSN_PARAM : RSN_NONE;                       // R7
            rspBitmap    <= errMap;  // R16
          end
        end
        S_RESP:
          if (rspReady)
          begin
            state     <= S_HDR;
            byteCnt   <= 5'h00;
            rxType    <= 8'h00;
            tlvIdx    <= 8'h00;
            commitIdx <= 6'h00;
            errMap    <= 32'h0000_0000;
          end
      endcase
      // end of frame overrides the step above
      if (take && cmdLast)
      begin
        if (ownCmd)
        begin
          state <= S_COMMIT;  // R11
          if (truncated && tlvInRange)
            errMap[slotIdx] <= 1'b1;
        end
        else
        begin
          state   <= S_HDR;
          byteCnt <= 5'h00;
          rxType  <= 8'h00;
          tlvIdx  <= 8'h00;
          errMap  <= 32'h0000_0000;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // staging of received values
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (take && tlvInRange && state == S_CODE)
    begin
      stageCode[slotIdx] <= cmdData;
      stageLen[slotIdx]  <= curLen;
      stageVal[slotIdx]  <= 32'h0000_0000;
    end
    else if (take && tlvInRange && state == S_VAL && valSeen < LEN_U32)
      stageVal[slotIdx] <= {stageVal[slotIdx][23:0], cmdData};
  end

  // ---------------------------------------------------------------
  // committed attribute store
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < STORE_SLOTS; i++)
      begin
        storeLen[i] <= 8'h00;
        storeVal[i] <= 32'h0000_0000;
      end
    end
    else if (commitWrite)  // R13
    begin
      storeLen[stageCode[commitIdx[4:0]][5:0]] <= stageLen[commitIdx[4:0]];      // R2 R5
      storeVal[stageCode[commitIdx[4:0]][5:0]] <= stageVal[commitIdx[4:0]];
    end
  end

  // ---------------------------------------------------------------
  // register bus write side
  // ---------------------------------------------------------------
  assign s_axi_awready = !awHave && !s_axi_bvalid;
  assign s_axi_wready  = !wHave && !s_axi_bvalid;
  assign wrFire        = ce && awHave && wHave;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      awHave       <= 1'b0;
      wHave        <= 1'b0;
      awAddrReg    <= 8'h00;
      wDataReg     <= 32'h0000_0000;
      wStrbReg     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
      protoReg     <= PROTO_RESET;
      irqMask      <= IRQ_MASK_RESET;
      attrSel      <= 6'h00;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHave    <= 1'b1;
        awAddrReg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHave    <= 1'b1;
        wDataReg <= s_axi_wdata;
        wStrbReg <= s_axi_wstrb;
      end
      if (wrFire)
      begin
        awHave       <= 1'b0;
        wHave        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= RESP_OKAY;
        unique case (awAddrReg)
          REG_CTRL:       protoReg <= strb_byte(protoReg, wDataReg, wStrbReg, 0);
          REG_IRQ_MASK:   irqMask  <= wStrbReg[0] ? wDataReg[1:0] : irqMask;
          REG_ATTR_SEL:   attrSel  <= wStrbReg[0] ? wDataReg[5:0] : attrSel;
          REG_RESULT, REG_BITMAP, REG_IRQ_STATUS, REG_ATTR_LEN, REG_ATTR_VAL: ;
          default:        s_axi_bresp <= RESP_SLVERR;
        endcase
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // register bus read side
  // ---------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;
  assign rdFire        = ce && s_axi_arvalid && s_axi_arready;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end
    else if (ce)
    begin
      if (rdFire)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OKAY;
        unique case (s_axi_araddr)
          REG_CTRL:       s_axi_rdata <= {24'h000000, protoReg};
          REG_RESULT:     s_axi_rdata <= {rspCode, rspReason};
          REG_BITMAP:     s_axi_rdata <= rspBitmap;
          REG_IRQ_STATUS: s_axi_rdata <= {30'h0000_0000, irqStatus};
          REG_IRQ_MASK:   s_axi_rdata <= {30'h0000_0000, irqMask};
          REG_ATTR_SEL:   s_axi_rdata <= {26'h000_0000, attrSel};
          REG_ATTR_LEN:   s_axi_rdata <= {24'h000000, storeLen[attrSel]};
          REG_ATTR_VAL:   s_axi_rdata <= storeVal[attrSel];
          default:
          begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // interrupt: bit0 applied, bit1 failed; read clears, set wins
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      irqStatus <= 2'h0;
    else if (ce)
      irqStatus <= (irqStatus & ~{2{rdFire && s_axi_araddr == REG_IRQ_STATUS}}) |
                   {commitDone && cmdFail, commitDone && !cmdFail};
  end

  assign irq = |(irqStatus & irqMask);

endmodule // boot_config_set_handler
`default_nettype wire

// *** hdl/boot_cfg_pkg.sv ***
// What this block does
// [R1] attribute code bits 7:0, length 15:8; groups of six, stride eight, 0x3E up reserved
// [R2] accepted attribute values are applied one by one in arrival order
// [R3] string values are plain ASCII with no terminator; other bytes mark the TLV bad
// [R4] sender puts partition selector zero when partitioning is absent or off
// [R5] a zero length clears the stored attribute value to empty
// [R6] sender places at most thirty-two TLVs in one command
// [R7] unsupported boot protocol type fails with the parameter-invalid reason
// [R8] the write command is recognised by type code 0x2E
// [R9] the response carries type code 0xAE
// [R10] bytes 16-19 hold partition, reserved, protocol, TLV count; TLVs from byte 20
// [R11] every command without checksum or identifier fault gets a response
// [R12] completed and no error with zero bitmap only when all TLVs were clean
// [R13] any bad TLV fails the whole command and discards all staged values
// [R14] the bitmap reports a status for every TLV received
// [R15] response holds codes, then the bitmap, then checksum and pad
// [R16] bitmap bit n is TLV n+1; bits of unsent TLVs are zero
// [R17] bitmap bit one means error found, zero means clean or absent
// [R18] TLVs are packed back to back, value exactly as long as its length
package boot_cfg_pkg;

  // ---------------------------------------------------------------
  // packet layout
  // ---------------------------------------------------------------
  localparam logic [7:0]  CMD_TYPE        = 8'h2E;
  localparam logic [7:0]  RSP_TYPE        = 8'hAE;
  localparam logic [4:0]  HDR_TYPE_POS    = 5'h04;
  localparam logic [4:0]  PART_POS        = 5'h10;
  localparam logic [4:0]  PROTO_POS       = 5'h12;
  localparam logic [4:0]  COUNT_POS       = 5'h13;
  localparam int          TLV_LIMIT       = 32;
  localparam logic [7:0]  CODE_RSVD_FIRST = 8'h3E;
  localparam logic [7:0]  CODE_STRIDE     = 8'h08;
  localparam int          STORE_SLOTS     = 64;

  // ---------------------------------------------------------------
  // attribute kinds by position inside a group
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {KIND_STR, KIND_BOOL, KIND_U32, KIND_RSVD} attr_kind_t;
  localparam logic [7:0]  SLOT_BOOL       = 8'h03;
  localparam logic [7:0]  SLOT_U32_LAST   = 8'h05;
  localparam logic [7:0]  LEN_BOOL        = 8'h01;
  localparam logic [7:0]  LEN_U32         = 8'h04;
  localparam logic [7:0]  ASCII_LOW       = 8'h20;
  localparam logic [7:0]  ASCII_HIGH      = 8'h7E;

  // ---------------------------------------------------------------
  // response and reason codes
  // ---------------------------------------------------------------
  localparam logic [15:0] RSP_COMPLETED   = 16'h0000;
  localparam logic [15:0] RSP_FAILED      = 16'h0001;
  localparam logic [15:0] RSN_NONE        = 16'h0000;
  localparam logic [15:0] RSN_PARAM       = 16'h0002;

  // ---------------------------------------------------------------
  // register map and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  REG_CTRL        = 8'h00;
  localparam logic [7:0]  REG_RESULT      = 8'h04;
  localparam logic [7:0]  REG_BITMAP      = 8'h08;
  localparam logic [7:0]  REG_IRQ_STATUS  = 8'h0C;
  localparam logic [7:0]  REG_IRQ_MASK    = 8'h10;
  localparam logic [7:0]  REG_ATTR_SEL    = 8'h14;
  localparam logic [7:0]  REG_ATTR_LEN    = 8'h18;
  localparam logic [7:0]  REG_ATTR_VAL    = 8'h1C;
  localparam logic [7:0]  PROTO_RESET     = 8'h05;  // arbitrary
  localparam logic [1:0]  IRQ_MASK_RESET  = 2'h0;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  typedef enum logic [2:0] {S_HDR, S_LEN, S_CODE, S_VAL, S_SKIP, S_COMMIT, S_RESP} parse_state_t;

endpackage

// *** dv/boot_config_set_handler_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module boot_config_set_handler_assertions
  import boot_cfg_pkg::*;
#(
  parameter int MAX_TLVS = TLV_LIMIT
) (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        ce,
  input wire logic        cmdValid,
  input wire logic        cmdLast,
  input wire logic        cmdDrop,
  input wire logic        cmdReady,
  input wire logic        rspValid,
  input wire logic        rspReady,
  input wire logic [7:0]  rspType,
  input wire logic [15:0] rspCode,
  input wire logic [15:0] rspReason,
  input wire logic [31:0] rspBitmap,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  AST_RSP_TYPE:
    assert property (rspValid |-> rspType == RSP_TYPE) else $error("wrong response type");
  AST_OK_CLEAN:
    assert property (rspValid && rspCode == RSP_COMPLETED |-> rspBitmap == 32'h0 && rspReason == RSN_NONE)
      else $error("completed with error bits");
  AST_ERR_FAILS:
    assert property (rspValid && rspBitmap != 32'h0 |-> rspCode == RSP_FAILED) else $error("bad tlv not failed");
  AST_RSP_HOLD:
    assert property (rspValid && !rspReady |=> rspValid && $stable(rspBitmap) && $stable(rspCode))
      else $error("response changed before taken");
  AST_DROP_SILENT:
    assert property (cmdValid && cmdReady && ce && cmdLast && cmdDrop |=> !rspValid [*4])
      else $error("dropped packet answered");
  AST_RSP_BOUND:
    assert property (cmdValid && cmdReady && ce && cmdLast && !cmdDrop |-> ##[2:40] rspValid)
      else $error("no response");
  AST_BUSY_REFUSE:
    assert property (rspValid |-> !cmdReady) else $error("command taken during response");
  AST_RSP_DONE:
    assert property (rspValid && rspReady && ce |=> !rspValid) else $error("response not released");
  AST_READ_ANSWER:
    assert property (s_axi_arvalid && s_axi_arready && ce |=> s_axi_rvalid) else $error("read not answered");
  AST_WRITE_HOLD:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");

  COV_CLEAN: cover property (rspValid && rspReady && rspCode == RSP_COMPLETED);
  COV_FAIL: cover property (rspValid && rspReady && rspCode == RSP_FAILED);
  COV_DROP: cover property (cmdValid && cmdReady && cmdLast && cmdDrop);
endmodule  // boot_config_set_handler_assertions

bind boot_config_set_handler boot_config_set_handler_assertions #(.MAX_TLVS(MAX_TLVS)) i_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .cmdValid(cmdValid), .cmdLast(cmdLast),
  .cmdDrop(cmdDrop), .cmdReady(cmdReady), .rspValid(rspValid), .rspReady(rspReady),
  .rspType(rspType), .rspCode(rspCode), .rspReason(rspReason), .rspBitmap(rspBitmap),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp));
`default_nettype wire

// *** dv/mc_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module mc_model
  import boot_cfg_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       cmdReady,
  input  wire logic       rspValid,
  output logic            cmdValid,
  output logic [7:0]      cmdData,
  output logic            cmdLast,
  output logic            cmdDrop,
  output logic            rspReady
);
  logic [7:0] pk[$];
  logic [7:0] part = 8'h00;

  initial
  begin
    cmdValid = 1'b0;
    cmdData = 8'h00;
    cmdLast = 1'b0;
    cmdDrop = 1'b0;
    rspReady = 1'b0;
  end

  task hdr(input logic [7:0] proto, input logic [7:0] cnt);
    pk = {};
    for (int i = 0; i < 16; i++)
      pk.push_back(i == 4 ? CMD_TYPE : 8'h00);
    pk.push_back(part);
    pk.push_back(8'h00);
    pk.push_back(proto);
    pk.push_back(cnt);
  endtask

  task tv(input logic [7:0] len, input logic [7:0] code, input logic [31:0] v);
    pk.push_back(len);
    pk.push_back(code);
    for (int i = 0; i < len; i++)
      pk.push_back(v[31-8*i -: 8]);
  endtask

  task run(input logic drop, input int slow);
    for (int i = 0; i < 4; i++)
      pk.push_back(8'h00);
    @(posedge clk_sys);
    foreach (pk[i])
    begin
      cmdValid <= 1'b1;
      cmdData <= pk[i];
      cmdLast <= (i == pk.size() - 1);
      cmdDrop <= drop && (i == pk.size() - 1);
      do @(negedge clk_sys); while (!cmdReady);
      @(posedge clk_sys);
    end
    cmdValid <= 1'b0;
    cmdLast <= 1'b0;
    cmdDrop <= 1'b0;
    cmdData <= ~cmdData;
    if (!drop)
    begin
      @(posedge clk_sys);
      repeat (slow) @(posedge clk_sys);
      rspReady <= 1'b1;
      do @(negedge clk_sys); while (!rspValid);
      @(posedge clk_sys);
      rspReady <= 1'b0;
    end
  endtask
endmodule  // mc_model
`default_nettype wire

// *** dv/test_boot_config_set_handler.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_boot_config_set_handler;
  import boot_cfg_pkg::*;
  logic clk_sys, rst_n, ce, cmdValid, cmdLast, cmdDrop, cmdReady, rspValid, rspReady, irq;
  logic [7:0] cmdData, rspType, rspPartition, s_axi_awaddr, s_axi_araddr;
  logic [15:0] rspCode, rspReason;
  logic [31:0] rspBitmap, s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int n_errors, check_count;

  boot_config_set_handler i_boot_config_set_handler (
    .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .cmdValid(cmdValid), .cmdData(cmdData),
    .cmdLast(cmdLast), .cmdDrop(cmdDrop), .cmdReady(cmdReady), .rspValid(rspValid),
    .rspReady(rspReady), .rspType(rspType), .rspPartition(rspPartition), .rspCode(rspCode),
    .rspReason(rspReason), .rspBitmap(rspBitmap), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .irq(irq));

  mc_model i_mc_model (.clk_sys(clk_sys), .cmdReady(cmdReady), .rspValid(rspValid), .cmdValid(cmdValid),
    .cmdData(cmdData), .cmdLast(cmdLast), .cmdDrop(cmdDrop), .rspReady(rspReady));

  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task complete_run;
    if (n_errors == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    fork
      begin
        do @(negedge clk_sys); while (!s_axi_awready);
        @(posedge clk_sys);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do @(negedge clk_sys); while (!s_axi_wready);
        @(posedge clk_sys);
        s_axi_wvalid <= 1'b0;
      end
    join
    do @(negedge clk_sys); while (!s_axi_bvalid);
    rr = s_axi_bresp;
    @(posedge clk_sys);
    s_axi_bready <= 1'b0;
  endtask

  task rd_reg(input logic [7:0] a);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge clk_sys); while (!s_axi_arready);
    @(posedge clk_sys);
    s_axi_arvalid <= 1'b0;
    do @(negedge clk_sys); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    @(posedge clk_sys);
    s_axi_rready <= 1'b0;
  endtask

  task attr(input logic [7:0] c, input logic [31:0] n, input logic [31:0] v);
    wr_reg(REG_ATTR_SEL, 32'(c));
    rd_reg(REG_ATTR_LEN);
    chk(rd, n);
    rd_reg(REG_ATTR_VAL);
    chk(rd, v);
  endtask

  task t_regs;
    rd_reg(REG_CTRL);
    chk(rd, 32'(PROTO_RESET));
    rd_reg(8'h40);
    chk(32'(rr), 32'(RESP_SLVERR));
    rd_reg(REG_IRQ_MASK);
    chk(rd, 32'(IRQ_MASK_RESET));
    wr_reg(REG_IRQ_MASK, 32'h3);
    chk(32'(rr), 32'(RESP_OKAY));
  endtask

  task t_clean;
    i_mc_model.hdr(PROTO_RESET, 8'h04);
    i_mc_model.tv(8'h04, 8'h05, 32'hAAAA5555);
    i_mc_model.tv(8'h04, 8'h05, 32'h00000007);
    i_mc_model.tv(8'h01, 8'h03, 32'h01000000);
    i_mc_model.tv(8'h02, 8'h00, 32'h41420000);
    i_mc_model.run(1'b0, 3);
    chk(32'(rspType), 32'(RSP_TYPE));
    chk({rspCode, rspReason}, {RSP_COMPLETED, RSN_NONE});
    chk(rspBitmap, 32'h0);
    attr(8'h05, 32'h4, 32'h7);
    @(negedge clk_sys);
    chk(32'(irq), 32'h1);
    rd_reg(REG_IRQ_STATUS);
    chk(rd, 32'h1);
    @(negedge clk_sys);
    chk(32'(irq), 32'h0);
  endtask

  task t_bad;
    i_mc_model.hdr(PROTO_RESET, 8'h05);
    i_mc_model.tv(8'h00, 8'h05, 32'h0);
    i_mc_model.tv(8'h01, 8'h06, 32'h01000000);
    i_mc_model.tv(8'h02, 8'h0B, 32'h01010000);
    i_mc_model.tv(8'h01, 8'h3E, 32'h41000000);
    i_mc_model.tv(8'h02, 8'h08, 32'h41000000);
    i_mc_model.run(1'b0, 0);
    chk(32'(rspCode), 32'(RSP_FAILED));
    chk(rspBitmap, 32'h0000001E);
    attr(8'h05, 32'h4, 32'h7);
    rd_reg(REG_IRQ_STATUS);
    chk(rd, 32'h2);
  endtask

  task t_zero;
    i_mc_model.hdr(PROTO_RESET, 8'h01);
    i_mc_model.tv(8'h00, 8'h05, 32'h0);
    i_mc_model.run(1'b0, 1);
    chk(32'(rspCode), 32'(RSP_COMPLETED));
    attr(8'h05, 32'h0, 32'h0);
    rd_reg(REG_IRQ_STATUS);
    chk(rd, 32'h1);
  endtask

  task t_proto;
    wr_reg(REG_IRQ_MASK, 32'h1);
    i_mc_model.part = 8'h03;
    i_mc_model.hdr(8'h07, 8'h01);
    i_mc_model.tv(8'h01, 8'h03, 32'h01000000);
    i_mc_model.run(1'b0, 0);
    chk({rspCode, rspReason}, {RSP_FAILED, RSN_PARAM});
    chk(32'(rspPartition), 32'h3);
    @(negedge clk_sys);
    chk(32'(irq), 32'h0);
    rd_reg(REG_IRQ_STATUS);
    chk(rd, 32'h2);
  endtask

  task t_drop;
    i_mc_model.hdr(PROTO_RESET, 8'h01);
    i_mc_model.tv(8'h01, 8'h03, 32'h01000000);
    i_mc_model.run(1'b1, 0);
    repeat (8) @(negedge clk_sys);
    chk(32'(rspValid), 32'h0);
    i_mc_model.hdr(PROTO_RESET, 8'h01);
    i_mc_model.tv(8'h01, 8'h03, 32'h00000000);
    i_mc_model.run(1'b0, 0);
    chk(32'(rspCode), 32'(RSP_COMPLETED));
  endtask

  task t_full;
    i_mc_model.hdr(PROTO_RESET, 8'h20);
    for (int i = 0; i < 31; i++)
      i_mc_model.tv(8'h01, 8'h03, 32'h0);
    i_mc_model.tv(8'h01, 8'h07, 32'h0);
    i_mc_model.run(1'b0, 2);
    chk(rspBitmap, 32'h80000000);
  endtask

  initial
  begin
    #5_000_000;
    n_errors++;
    complete_run();
  end

  initial
  begin
    rst_n = 1'b0;
    ce = 1'b1;
    s_axi_wstrb = 4'hF;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    n_errors = 0;
    check_count = 0;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_regs();
    t_clean();
    t_bad();
    t_zero();
    t_proto();
    t_drop();
    t_full();
    complete_run();
  end
endmodule  // test_boot_config_set_handler
`default_nettype wire
